// ==== adc_cfg_pkg.sv ====
// Purpose: Shared constants and carriers of the converter configuration bank.
// Assumes: 13-bit register address, 8-bit data, one clock.
// Notes:   Each offset and reset value is named once here.

package adc_cfg_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [12:0] ADDR_CHANNEL_SELECT    = 13'h0005;
  localparam logic [12:0] ADDR_PATTERN_ONE_LOW   = 13'h0019;
  localparam logic [12:0] ADDR_PATTERN_ONE_HIGH  = 13'h001A;
  localparam logic [12:0] ADDR_PATTERN_TWO_LOW   = 13'h001B;
  localparam logic [12:0] ADDR_PATTERN_TWO_HIGH  = 13'h001C;
  localparam logic [12:0] ADDR_SERIALIZER        = 13'h0021;
  localparam logic [12:0] ADDR_CHANNEL_STATUS    = 13'h0022;
  localparam logic [12:0] ADDR_TRANSFER          = 13'h00FF;
  localparam logic [12:0] ADDR_OVERRIDE          = 13'h0100;
  localparam logic [12:0] ADDR_IO_CONTROL_TWO    = 13'h0101;
  localparam logic [12:0] ADDR_IO_CONTROL_THREE  = 13'h0102;
  localparam logic [12:0] ADDR_SYNC              = 13'h0109;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CHANNEL_SELECT = 8'h3F;
  localparam logic [7:0] RST_ZERO           = 8'h00;
  localparam logic [7:0] RST_SERIALIZER     = 8'h32;

  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int NUM_DATA_CH   = 4;   // Data channels, select bits 3:0
  localparam int NUM_ALL_CH    = 6;   // Plus two clock outputs, bits 5:4
  localparam int BIT_TRANSFER  = 0;   // Transfer commit bit
  localparam int BIT_PD        = 0;   // Channel power-down
  localparam int BIT_ORST      = 1;   // Channel output reset
  localparam int BIT_PULL_OFF  = 0;   // Data pin pull-down disable
  localparam int BIT_CM_PD     = 3;   // Common-mode output power-down
  localparam int BIT_SYNC_EN   = 0;   // Sync enable
  localparam int BIT_SYNC_NEXT = 1;   // Sync next only
  localparam logic [7:0] MASK_SERIALIZER = 8'hF7;
  localparam logic [7:0] MASK_STATUS     = 8'h03;
  localparam logic [7:0] MASK_OVERRIDE   = 8'h77;
  localparam logic [7:0] MASK_SYNC       = 8'h03;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       lsb_first;   // Bit 7
    logic [2:0] lane_mode;   // Bits 6:4: 000..011 two-lane, 100 one-lane
    logic       open_bit;    // Bit 3, reads zero
    logic       frame_2x;    // Bit 2
    logic [1:0] word_len;    // Bits 1:0: 10 = 12 bits, 11 = 10 bits
  } serializer_t;

  typedef struct packed {
    logic       open_hi;     // Bit 7, reads zero
    logic       enable;      // Bit 6
    logic [1:0] resolution;  // Bits 5:4
    logic       open_mid;    // Bit 3, reads zero
    logic [2:0] rate_cap;    // Bits 2:0: 20,40,50,65,80,105,125 MSPS
  } override_t;

endpackage

// ==== adc_output_config_registers.sv ====
// Purpose: Configuration register bank written by the serial port host.
// Assumes: Serial front end delivers decoded byte accesses on clk.
// Notes:   Reads return data one cycle after rd_en.

`timescale 1ns/1ps

module adc_output_config_registers (
  input  wire logic                    clk,              // 100 MHz clock
  input  wire logic                    rstn,             // Power-on reset, low
  input  wire logic [12:0]             addr,             // Register address
  input  wire logic [7:0]              wdata,            // Write data
  input  wire logic                    wr_en,            // Write strobe, one cycle
  input  wire logic                    rd_en,            // Read strobe, one cycle
  output logic      [7:0]              rdata,            // Read data, registered
  output logic                         rvalid,           // Read data valid pulse
  input  wire logic                    sync_in,          // Sync pin, asynchronous
  output logic      [15:0]             pattern_one,      // User pattern one
  output logic      [15:0]             pattern_two,      // User pattern two
  output adc_cfg_pkg::serializer_t     serializer,       // Serializer options
  output logic      [5:0]              ch_power_down,    // Per channel power-down
  output logic      [5:0]              ch_output_reset,  // Per channel output reset
  output adc_cfg_pkg::override_t       override_active,  // Committed override
  output logic                         sdio_pulldown_en, // Data pin pull-down on
  output logic                         common_mode_pd,   // Common-mode output off
  output logic                         divider_realign   // Realign pulse
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] channel_select, next_channel_select;   // Local write targets
  logic [7:0] pat [4], next_pat [4];                  // Pattern bytes
  logic [7:0] ser_reg, next_ser_reg;                  // Serializer control
  logic [7:0] status [6], next_status [6];            // Per channel status
  logic [7:0] ovr_shadow, next_ovr_shadow;            // Override, uncommitted
  logic [7:0] ovr_live, next_ovr_live;                // Override, committed
  logic [7:0] io_two, next_io_two;                    // User I/O control 2
  logic [7:0] io_three, next_io_three;                // User I/O control 3
  logic [7:0] sync_reg, next_sync_reg;                // Sync control
  logic [7:0] next_rdata;                             // Read mux result
  logic       next_rvalid;                            // Read answer
  logic       sync_meta, sync_q, sync_prev;           // Pin synchroniser
  logic       sync_event;                             // Rising edge of pin
  logic       next_realign;                           // Realign request

  // ---------------------------------------------------------------
  // Sync pin synchroniser
  // ---------------------------------------------------------------
  // Two flops before use; edge detect reads the second and its one-cycle delayed copy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_meta <= 1'b0;
      sync_q    <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_meta <= sync_in;
      sync_q    <= sync_meta;
      sync_prev <= sync_q;
    end
  end

  assign sync_event = sync_q & ~sync_prev;

  // ---------------------------------------------------------------
  // Register next values
  // ---------------------------------------------------------------
  // All writes land the cycle they are taken
  always_comb begin
    next_channel_select = channel_select;
    next_pat            = pat;
    next_ser_reg        = ser_reg;
    next_status         = status;
    next_ovr_shadow     = ovr_shadow;
    next_ovr_live       = ovr_live;
    next_io_two         = io_two;
    next_io_three       = io_three;
    next_sync_reg       = sync_reg;
    next_realign        = 1'b0;
    if (wr_en) begin
      case (addr)
        adc_cfg_pkg::ADDR_CHANNEL_SELECT: begin
          next_channel_select = {2'h0, wdata[5:0]};
        end
        adc_cfg_pkg::ADDR_PATTERN_ONE_LOW:  next_pat[0] = wdata;
        adc_cfg_pkg::ADDR_PATTERN_ONE_HIGH: next_pat[1] = wdata;
        adc_cfg_pkg::ADDR_PATTERN_TWO_LOW:  next_pat[2] = wdata;
        adc_cfg_pkg::ADDR_PATTERN_TWO_HIGH: next_pat[3] = wdata;
        adc_cfg_pkg::ADDR_SERIALIZER: begin
          // Global: selection is ignored
          next_ser_reg = wdata & adc_cfg_pkg::MASK_SERIALIZER;
        end
        adc_cfg_pkg::ADDR_CHANNEL_STATUS: begin
          // Local: only selected channels take the write
          for (int i = 0; i < adc_cfg_pkg::NUM_ALL_CH; i++) begin
            if (channel_select[i]) begin
              next_status[i] = wdata & adc_cfg_pkg::MASK_STATUS;
            end
          end
        end
        adc_cfg_pkg::ADDR_TRANSFER: begin
          // Commit the staged override
          if (wdata[adc_cfg_pkg::BIT_TRANSFER]) begin
            next_ovr_live = ovr_shadow;
          end
        end
        adc_cfg_pkg::ADDR_OVERRIDE: begin
          next_ovr_shadow = wdata & adc_cfg_pkg::MASK_OVERRIDE;
        end
        adc_cfg_pkg::ADDR_IO_CONTROL_TWO: begin
          next_io_two = {7'h00, wdata[adc_cfg_pkg::BIT_PULL_OFF]};
        end
        adc_cfg_pkg::ADDR_IO_CONTROL_THREE: begin
          next_io_three = wdata & 8'h08;
        end
        adc_cfg_pkg::ADDR_SYNC: begin
          next_sync_reg = wdata & adc_cfg_pkg::MASK_SYNC;
        end
        default: begin
          // Unmapped write is ignored
        end
      endcase
    end
    // Sync event: realign; when armed for one event only, drop enable unless the sync register is written that cycle
    if (sync_event && sync_reg[adc_cfg_pkg::BIT_SYNC_EN]) begin
      next_realign = 1'b1;
      if (sync_reg[adc_cfg_pkg::BIT_SYNC_NEXT] &&
          !(wr_en && addr == adc_cfg_pkg::ADDR_SYNC)) begin
        next_sync_reg[adc_cfg_pkg::BIT_SYNC_EN] = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channel_select  <= adc_cfg_pkg::RST_CHANNEL_SELECT;
      pat             <= '{default: adc_cfg_pkg::RST_ZERO};
      ser_reg         <= adc_cfg_pkg::RST_SERIALIZER;
      status          <= '{default: adc_cfg_pkg::RST_ZERO};
      ovr_shadow      <= adc_cfg_pkg::RST_ZERO;
      ovr_live        <= adc_cfg_pkg::RST_ZERO;
      io_two          <= adc_cfg_pkg::RST_ZERO;
      io_three        <= adc_cfg_pkg::RST_ZERO;
      sync_reg        <= adc_cfg_pkg::RST_ZERO;
      divider_realign <= 1'b0;
    end else begin
      channel_select  <= next_channel_select;
      pat             <= next_pat;
      ser_reg         <= next_ser_reg;
      status          <= next_status;
      ovr_shadow      <= next_ovr_shadow;
      ovr_live        <= next_ovr_live;
      io_two          <= next_io_two;
      io_three        <= next_io_three;
      sync_reg        <= next_sync_reg;
      divider_realign <= next_realign;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Local register reads the lowest selected channel
  always_comb begin
    next_rdata  = 8'h00;
    next_rvalid = rd_en;
    if (rd_en) begin
      case (addr)
        adc_cfg_pkg::ADDR_CHANNEL_SELECT:   next_rdata = channel_select;
        adc_cfg_pkg::ADDR_PATTERN_ONE_LOW:  next_rdata = pat[0];
        adc_cfg_pkg::ADDR_PATTERN_ONE_HIGH: next_rdata = pat[1];
        adc_cfg_pkg::ADDR_PATTERN_TWO_LOW:  next_rdata = pat[2];
        adc_cfg_pkg::ADDR_PATTERN_TWO_HIGH: next_rdata = pat[3];
        adc_cfg_pkg::ADDR_SERIALIZER:       next_rdata = ser_reg;
        adc_cfg_pkg::ADDR_CHANNEL_STATUS: begin
          for (int i = adc_cfg_pkg::NUM_ALL_CH - 1; i >= 0; i--) begin
            if (channel_select[i]) begin
              next_rdata = status[i];
            end
          end
        end
        adc_cfg_pkg::ADDR_OVERRIDE:         next_rdata = ovr_shadow;
        adc_cfg_pkg::ADDR_IO_CONTROL_TWO:   next_rdata = io_two;
        adc_cfg_pkg::ADDR_IO_CONTROL_THREE: next_rdata = io_three;
        adc_cfg_pkg::ADDR_SYNC:             next_rdata = sync_reg;
        default:                            next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign pattern_one      = {pat[1], pat[0]};
  assign pattern_two      = {pat[3], pat[2]};
  assign serializer       = adc_cfg_pkg::serializer_t'(ser_reg);
  // Only the committed copy reaches the converter; rate is a cap only
  assign override_active  = adc_cfg_pkg::override_t'(ovr_live);
  assign sdio_pulldown_en = ~io_two[adc_cfg_pkg::BIT_PULL_OFF];
  assign common_mode_pd   = io_three[adc_cfg_pkg::BIT_CM_PD];

  // Per channel status fan-out
  genvar g;
  generate
    for (g = 0; g < adc_cfg_pkg::NUM_ALL_CH; g++) begin : g_ch
      assign ch_power_down[g]   = status[g][adc_cfg_pkg::BIT_PD];
      assign ch_output_reset[g] = status[g][adc_cfg_pkg::BIT_ORST];
    end
  endgenerate

endmodule // adc_output_config_registers

// ==== adc_cfg_chk.sv ====
// Purpose: Port-level checks of the configuration bank.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to every bank instance.
`timescale 1ns/1ps
module adc_cfg_chk (
  input wire logic                    clk,              // Clock
  input wire logic                    rstn,             // Reset, low
  input wire logic [12:0]             addr,             // Address
  input wire logic [7:0]              wdata,            // Write data
  input wire logic                    wr_en,            // Write strobe
  input wire logic                    rd_en,            // Read strobe
  input wire logic [7:0]              rdata,            // Read data
  input wire logic                    rvalid,           // Read valid
  input wire logic                    sync_in,          // Sync pin
  input wire logic [15:0]             pattern_one,      // Pattern one
  input wire logic [15:0]             pattern_two,      // Pattern two
  input wire adc_cfg_pkg::serializer_t serializer,      // Serializer
  input wire adc_cfg_pkg::override_t  override_active,  // Committed override
  input wire logic                    sdio_pulldown_en, // Pull-down on
  input wire logic                    common_mode_pd,   // Common-mode off
  input wire logic                    divider_realign   // Realign pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_ser_write: assert property (wr_en && addr == adc_cfg_pkg::ADDR_SERIALIZER |=>
    serializer == ($past(wdata) & adc_cfg_pkg::MASK_SERIALIZER)) else $error("serializer write");
  chk_pat_high: assert property (wr_en && addr == adc_cfg_pkg::ADDR_PATTERN_TWO_HIGH |=>
    pattern_two[15:8] == $past(wdata)) else $error("pattern high byte");
  chk_ovr_hold: assert property (!(wr_en && addr == adc_cfg_pkg::ADDR_TRANSFER && wdata[0])
    |=> $stable(override_active)) else $error("override moved without commit");
  chk_pull_off: assert property (wr_en && addr == adc_cfg_pkg::ADDR_IO_CONTROL_TWO |=>
    sdio_pulldown_en == !$past(wdata[0])) else $error("pull-down control");
  chk_cm_write: assert property (wr_en && addr == adc_cfg_pkg::ADDR_IO_CONTROL_THREE |=>
    common_mode_pd == $past(wdata[3])) else $error("common-mode control");
  chk_xfer_read: assert property (rd_en && addr == adc_cfg_pkg::ADDR_TRANSFER |=>
    rvalid && rdata == 8'h00) else $error("transfer readback");
  chk_ser_read: assert property (rd_en && !wr_en && addr == adc_cfg_pkg::ADDR_SERIALIZER |=>
    rvalid && rdata == serializer) else $error("serializer readback");
  chk_realign_one: assert property (divider_realign |=> !divider_realign)
    else $error("realign longer than one cycle");
  chk_realign_cause: assert property (divider_realign |->
    $past(sync_in, 2) || $past(sync_in, 3) || $past(sync_in, 4)) else $error("realign no sync");
  cover property (override_active.enable);
  cover property (divider_realign);
  cover property (rvalid && rdata != 8'h00);
endmodule // adc_cfg_chk

bind adc_output_config_registers adc_cfg_chk chk_i (.clk(clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rvalid(rvalid),
  .sync_in(sync_in), .pattern_one(pattern_one), .pattern_two(pattern_two),
  .serializer(serializer), .override_active(override_active),
  .sdio_pulldown_en(sdio_pulldown_en), .common_mode_pd(common_mode_pd),
  .divider_realign(divider_realign));

// ==== adc_host.sv ====
// Purpose: Host model driving the bank's register port.
// Assumes: Requests launched just after a rising edge.
// Notes:   Released lines show inverted values.
`timescale 1ns/1ps
module adc_host (
  input  wire logic        clk,    // Bank clock
  output logic      [12:0] addr,   // Address
  output logic      [7:0]  wdata,  // Write data
  output logic             wr_en,  // Write strobe
  output logic             rd_en,  // Read strobe
  input  wire logic [7:0]  rdata,  // Read data
  input  wire logic        rvalid  // Read valid
);
  initial begin
    addr  = 13'h0000;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // One write, taken at the second edge
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
    #1;
  endtask
  // One read, data sampled once the answer has landed
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr  <= ~a;
    #1;
    d = rdata;
    v = rvalid;
  endtask
  // Applies the staged override in its own write
  task automatic commit();
    wr(adc_cfg_pkg::ADDR_TRANSFER, 8'h01);
  endtask
endmodule // adc_host

// ==== tb_adc_output_config_registers.sv ====
// Purpose: Self-checking bench of the configuration bank.
// Assumes: Host model drives the register port.
// Notes:   Expected values come from the register map.
`timescale 1ns/1ps
module tb_adc_output_config_registers;
  logic                     clk, rstn, sync_in, wr_en, rd_en, rvalid, pd_en, cm_pd, realign;
  logic [12:0]              addr;
  logic [7:0]               wdata, rdata, rd_d;
  logic                     rd_v;
  logic [15:0]              pattern_one, pattern_two;
  logic [5:0]               ch_pd, ch_rst;
  adc_cfg_pkg::serializer_t serializer;
  adc_cfg_pkg::override_t   ovr;
  int                       err_count, n_tests, n;
  adc_output_config_registers adc_output_config_registers_i (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rvalid(rvalid),
    .sync_in(sync_in), .pattern_one(pattern_one), .pattern_two(pattern_two),
    .serializer(serializer), .ch_power_down(ch_pd), .ch_output_reset(ch_rst),
    .override_active(ovr), .sdio_pulldown_en(pd_en), .common_mode_pd(cm_pd),
    .divider_realign(realign));
  adc_host adc_host_i (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .rvalid(rvalid));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [12:0] a, input logic [7:0] exp);
    adc_host_i.rd(a, rd_d, rd_v);
    chk({7'h00, rd_v}, 8'h01);
    chk(rd_d, exp);
  endtask
  // Counts realign pulses after one sync pin rise
  task automatic pulse();
    n = 0;
    @(posedge clk);
    sync_in <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      if (i == 4) sync_in <= 1'b0;
      #1;
      if (realign === 1'b1) n++;
    end
  endtask
  task automatic t_reset();
    chk(serializer, adc_cfg_pkg::RST_SERIALIZER);
    chk({7'h00, pd_en}, 8'h01);
    chk(pattern_one[7:0] | pattern_one[15:8] | pattern_two[7:0] | pattern_two[15:8], 8'h00);
    chk({2'b00, ch_pd | ch_rst}, 8'h00);
    chk(ovr | {7'h00, cm_pd} | {7'h00, realign}, 8'h00);
    rchk(adc_cfg_pkg::ADDR_CHANNEL_SELECT, adc_cfg_pkg::RST_CHANNEL_SELECT);
    $display("t_reset done");
  endtask
  task automatic t_patterns();
    logic [12:0] pa[4];
    logic [7:0]  pd[4];
    logic [31:0] all_pat;
    pa = '{adc_cfg_pkg::ADDR_PATTERN_ONE_LOW, adc_cfg_pkg::ADDR_PATTERN_ONE_HIGH,
           adc_cfg_pkg::ADDR_PATTERN_TWO_LOW, adc_cfg_pkg::ADDR_PATTERN_TWO_HIGH};
    pd = '{8'hA5, 8'h3C, 8'h01, 8'hF0};
    for (int i = 0; i < 4; i++) begin
      adc_host_i.wr(pa[i], pd[i]);
      all_pat = {pattern_two, pattern_one};
      chk(all_pat[i*8 +: 8], pd[i]);
      rchk(pa[i], pd[i]);
    end
    $display("t_patterns done");
  endtask
  task automatic t_serializer();
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      v = {i[0], i[2:0], 1'b1, i[1], i[0] ? 2'b11 : 2'b10};
      adc_host_i.wr(adc_cfg_pkg::ADDR_SERIALIZER, v);
      chk(serializer, v & adc_cfg_pkg::MASK_SERIALIZER);
      rchk(adc_cfg_pkg::ADDR_SERIALIZER, v & adc_cfg_pkg::MASK_SERIALIZER);
    end
    $display("t_serializer done");
  endtask
  task automatic t_local();
    adc_host_i.wr(adc_cfg_pkg::ADDR_CHANNEL_SELECT, 8'h01);
    adc_host_i.wr(adc_cfg_pkg::ADDR_CHANNEL_STATUS, 8'h01);
    chk({2'b00, ch_pd}, 8'h01);
    adc_host_i.wr(adc_cfg_pkg::ADDR_PATTERN_ONE_LOW, 8'h5A);
    chk(pattern_one[7:0], 8'h5A);
    adc_host_i.wr(adc_cfg_pkg::ADDR_CHANNEL_SELECT, 8'h30);
    adc_host_i.wr(adc_cfg_pkg::ADDR_CHANNEL_STATUS, 8'h02);
    chk({2'b00, ch_pd}, 8'h01);
    chk({2'b00, ch_rst}, 8'h30);
    rchk(adc_cfg_pkg::ADDR_CHANNEL_STATUS, 8'h02);
    $display("t_local done");
  endtask
  task automatic t_override();
    logic [7:0] v, prev;
    prev = 8'h00;
    for (int c = 0; c < 7; c++) begin
      v = {2'b01, c[0] ? 2'b11 : 2'b10, 1'b0, c[2:0]};
      adc_host_i.wr(adc_cfg_pkg::ADDR_OVERRIDE, v);
      adc_host_i.wr(adc_cfg_pkg::ADDR_TRANSFER, 8'hFE);
      chk(ovr, prev);
      rchk(adc_cfg_pkg::ADDR_OVERRIDE, v);
      adc_host_i.commit();
      chk(ovr, v);
      prev = v;
    end
    rchk(adc_cfg_pkg::ADDR_TRANSFER, 8'h00);
    $display("t_override done");
  endtask
  task automatic t_io();
    adc_host_i.wr(adc_cfg_pkg::ADDR_IO_CONTROL_TWO, 8'h01);
    chk({7'h00, pd_en}, 8'h00);
    adc_host_i.wr(adc_cfg_pkg::ADDR_IO_CONTROL_THREE, 8'hFF);
    chk({7'h00, cm_pd}, 8'h01);
    rchk(adc_cfg_pkg::ADDR_IO_CONTROL_THREE, 8'h08);
    adc_host_i.wr(13'h0003, 8'hFF);
    rchk(13'h0003, 8'h00);
    $display("t_io done");
  endtask
  task automatic t_sync();
    pulse();
    chk(8'(n), 8'h00);
    adc_host_i.wr(adc_cfg_pkg::ADDR_SYNC, 8'h01);
    pulse();
    chk(8'(n), 8'h01);
    pulse();
    chk(8'(n), 8'h01);
    adc_host_i.wr(adc_cfg_pkg::ADDR_SYNC, 8'h03);
    pulse();
    chk(8'(n), 8'h01);
    rchk(adc_cfg_pkg::ADDR_SYNC, 8'h02);
    pulse();
    chk(8'(n), 8'h00);
    $display("t_sync done");
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    sync_in = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_patterns();
    t_serializer();
    t_local();
    t_override();
    t_io();
    t_sync();
    complete_run();
  end
  initial begin
    #300000;
    err_count++;
    complete_run();
  end
endmodule // tb_adc_output_config_registers
